// >>> rtl/pump_run_mode_sequencer.sv
`timescale 1ns/1ns
`include "pump_seq_cfg.svh"

module pump_run_mode_sequencer #(
    parameter int TICK_CYCLES = `TICK_CYCLES,
    parameter int DEB_TICKS = `DEBOUNCE_MS,
    parameter int TIME_W = 16
) (
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic [`ADDR_W-1:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WSTB_I,
    input wire logic RSTB_I,
    output logic [31:0] RDATA_O,
    input wire logic FWD_RUN_I,
    input wire logic REV_RUN_I,
    output logic RUNNING_O,
    output logic STOPPED_O,
    output logic CLOCKWISE_RUN_O,
    output logic COUNTERCLOCKWISE_RUN_O
);
    import pump_seq_pkg::*;

    localparam int TCW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

    // ****************************************
    // Millisecond tick divider
    // ****************************************
    logic [TCW-1:0] tick_cnt;
    logic [TCW-1:0] next_tick_cnt;
    logic tick;
    logic next_tick;

    always_comb begin
        next_tick = 1'b0;
        next_tick_cnt = tick_cnt + TCW'(1);
        if (tick_cnt == TCW'(TICK_CYCLES - 1)) begin
            next_tick_cnt = '0;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else begin
            tick_cnt <= next_tick_cnt;
            tick <= next_tick;
        end
    end

    // ****************************************
    // Remote inputs
    // ****************************************
    logic [1:0] raw_in;
    logic [1:0] clean_in;
    logic prev_req;
    remote_t rem;

    assign raw_in = {REV_RUN_I, FWD_RUN_I};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_remote
            remote_input_filter #(
                .DEB_TICKS(DEB_TICKS)
            ) u_filter (
                .clk_i(MCLK_I),
                .rst_i(RST_I),
                .tick_i(tick),
                .raw_i(raw_in[g]),
                .clean_o(clean_in[g])
            );
        end
    endgenerate

    // Forward wins if both contacts close
    assign rem.req = |clean_in;
    assign rem.rev = clean_in[1] & ~clean_in[0];
    assign rem.rise = rem.req & ~prev_req;

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            prev_req <= 1'b0;
        end else begin
            prev_req <= rem.req;
        end
    end

    // ****************************************
    // Register file
    // ****************************************
    mode_t mode;
    mode_t next_mode;
    logic [TIME_W-1:0] run_time;
    logic [TIME_W-1:0] next_run_time;
    logic [TIME_W-1:0] idle_time;
    logic [TIME_W-1:0] next_idle_time;
    logic [TIME_W-1:0] batch_load;
    logic [TIME_W-1:0] next_batch_load;
    logic [31:0] next_rdata;
    logic [TIME_W-1:0] remain;
    logic src_remote;
    logic dir_rev;
    key_cmd_t key;

    assign key.stop = WSTB_I && ADDR_I == `REG_KEY_CMD
        && WDATA_I[`KEY_STOP_BIT];
    assign key.start = WSTB_I && ADDR_I == `REG_KEY_CMD
        && (WDATA_I[`KEY_START_FWD_BIT] || WDATA_I[`KEY_START_REV_BIT]);
    assign key.rev = ~WDATA_I[`KEY_START_FWD_BIT];

    always_comb begin
        next_mode = mode;
        next_run_time = run_time;
        next_idle_time = idle_time;
        next_batch_load = batch_load;
        next_rdata = 32'h0;
        if (WSTB_I) begin
            unique case (ADDR_I)
                `REG_MODE: next_mode = mode_t'(WDATA_I[1:0]);
                `REG_RUN_TIME: next_run_time = WDATA_I[TIME_W-1:0];
                `REG_IDLE_TIME: next_idle_time = WDATA_I[TIME_W-1:0];
                `REG_BATCH_LOAD: next_batch_load = WDATA_I[TIME_W-1:0];
                default: ;
            endcase
        end
        if (RSTB_I) begin
            unique case (ADDR_I)
                `REG_MODE: next_rdata[1:0] = mode;
                `REG_RUN_TIME: next_rdata[TIME_W-1:0] = run_time;
                `REG_IDLE_TIME: next_rdata[TIME_W-1:0] = idle_time;
                `REG_BATCH_LOAD: next_rdata[TIME_W-1:0] = batch_load;
                `REG_STATUS: begin
                    next_rdata[`STAT_RUNNING_BIT] = RUNNING_O;
                    next_rdata[`STAT_REV_BIT] = dir_rev;
                    next_rdata[`STAT_REMOTE_BIT] = src_remote;
                    next_rdata[`STAT_REMAIN_LSB +: TIME_W] = remain;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            mode <= mode_t'(`RST_MODE);
            run_time <= TIME_W'(`RST_RUN_TIME);
            idle_time <= TIME_W'(`RST_IDLE_TIME);
            batch_load <= TIME_W'(`RST_BATCH_LOAD);
            RDATA_O <= 32'h0;
        end else begin
            mode <= next_mode;
            run_time <= next_run_time;
            idle_time <= next_idle_time;
            batch_load <= next_batch_load;
            RDATA_O <= next_rdata;
        end
    end

    // ****************************************
    // Run sequencer
    // ****************************************
    seq_state_t state;
    seq_state_t next_state;
    logic [TIME_W-1:0] timer;
    logic [TIME_W-1:0] next_timer;
    logic [TIME_W-1:0] next_remain;
    logic next_src_remote;
    logic next_dir_rev;
    logic expire;
    logic dropped;
    logic next_running;

    assign expire = tick && timer <= {{(TIME_W-1){1'b0}}, 1'b1};
    assign dropped = src_remote && !rem.req;

    always_comb begin
        next_state = state;
        next_remain = remain;
        next_src_remote = src_remote;
        next_dir_rev = dir_rev;
        next_timer = timer;
        if (tick && timer != '0) begin
            next_timer = timer - TIME_W'(1);
        end
        if (key.stop) begin
            next_state = ST_IDLE;
        end else if (key.start) begin
            next_src_remote = 1'b0;
            next_dir_rev = key.rev;
            next_timer = run_time;
            unique case (mode)
                MODE_MANUAL: next_state = ST_RUN;
                MODE_TIMED: next_state = ST_RUN;
                MODE_DOSE: next_state = ST_DOSE_ON;
                MODE_BATCH: begin
                    next_remain = batch_load;
                    next_state = (batch_load != '0) ? ST_BATCH_ON : ST_IDLE;
                end
            endcase
        end else begin
            unique case (state)
                ST_IDLE: begin
                    next_timer = run_time;
                    next_src_remote = 1'b1;
                    next_dir_rev = rem.rev;
                    unique case (mode)
                        MODE_MANUAL: begin
                            if (rem.req) next_state = ST_RUN;
                        end
                        MODE_TIMED: begin
                            if (rem.rise) next_state = ST_RUN;
                        end
                        MODE_DOSE: begin
                            if (rem.rise) next_state = ST_DOSE_ON;
                        end
                        MODE_BATCH: begin
                            if (rem.rise) begin
                                if (remain == '0) begin
                                    next_remain = batch_load;
                                end
                                if (remain != '0 || batch_load != '0) begin
                                    next_state = ST_BATCH_ON;
                                end
                            end
                        end
                    endcase
                end
                ST_RUN: begin
                    if (dropped) begin
                        next_state = ST_IDLE;
                    end else if (mode != MODE_MANUAL && expire) begin
                        next_state = ST_IDLE;
                    end
                end
                ST_DOSE_ON: begin
                    if (expire) begin
                        next_timer = idle_time;
                        next_state = dropped ? ST_IDLE : ST_DOSE_OFF;
                    end
                end
                ST_DOSE_OFF: begin
                    if (expire) begin
                        next_timer = run_time;
                        next_state = dropped ? ST_IDLE : ST_DOSE_ON;
                    end
                end
                ST_BATCH_ON: begin
                    if (expire) begin
                        next_timer = idle_time;
                        next_state = ST_BATCH_WAIT;
                    end
                end
                ST_BATCH_WAIT: begin
                    if (expire) begin
                        next_remain = remain - TIME_W'(1);
                        next_timer = run_time;
                        if (remain <= {{(TIME_W-1){1'b0}}, 1'b1}) begin
                            next_state = ST_IDLE;
                        end else if (dropped) begin
                            next_state = ST_IDLE;
                        end else begin
                            next_state = ST_BATCH_ON;
                        end
                    end
                end
                default: next_state = ST_IDLE;
            endcase
        end
        next_running = next_state == ST_RUN || next_state == ST_DOSE_ON
            || next_state == ST_BATCH_ON;
    end

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            state <= ST_IDLE;
            timer <= '0;
            remain <= '0;
            src_remote <= 1'b0;
            dir_rev <= 1'b0;
            RUNNING_O <= 1'b0;
            STOPPED_O <= 1'b1;
            CLOCKWISE_RUN_O <= 1'b0;
            COUNTERCLOCKWISE_RUN_O <= 1'b0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            remain <= next_remain;
            src_remote <= next_src_remote;
            dir_rev <= next_dir_rev;
            RUNNING_O <= next_running;
            STOPPED_O <= ~next_running;
            CLOCKWISE_RUN_O <= next_running & ~next_dir_rev;
            COUNTERCLOCKWISE_RUN_O <= next_running & next_dir_rev;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (RST_I);

    chk_stop_ends_run: assert property (
        key.stop |=> !RUNNING_O && STOPPED_O)
        else $error("keypad stop did not stop the pump");
    chk_stopped_complement: assert property (
        STOPPED_O == !RUNNING_O)
        else $error("stopped indicator not complement of running");
    chk_run_indicator: assert property (
        RUNNING_O == (state == ST_RUN || state == ST_DOSE_ON
            || state == ST_BATCH_ON))
        else $error("running indicator disagrees with sequencer");
    chk_manual_key_start: assert property (
        mode == MODE_MANUAL && key.start && !key.stop
        |=> RUNNING_O [*3] or (##[1:2] $past(key.stop)))
        else $error("manual keypad start did not keep running");
    chk_manual_remote_drop: assert property (
        state == ST_RUN && src_remote && !rem.req && !key.start
        |=> !RUNNING_O)
        else $error("remote release did not stop manual run");
    chk_timed_expiry: assert property (
        state == ST_RUN && mode == MODE_TIMED && expire
        && !key.start && !key.stop |=> state == ST_IDLE)
        else $error("timed run did not end at expiry");
    chk_timed_restart: assert property (
        mode == MODE_TIMED && key.start && !key.stop
        |=> timer == $past(run_time) && state == ST_RUN)
        else $error("keypad start did not restart timed run");
    chk_keypad_priority: assert property (
        state == ST_RUN && !src_remote && mode == MODE_MANUAL
        && !key.stop |=> RUNNING_O)
        else $error("remote input disturbed keypad run");
    chk_remote_rearm: assert property (
        state == ST_IDLE && mode == MODE_TIMED && !rem.rise
        && !key.start |=> !RUNNING_O)
        else $error("timed run started without remote reassertion");
    chk_dose_repeat: assert property (
        state == ST_DOSE_ON && expire && rem.req && !key.stop
        && !key.start |=> state == ST_DOSE_OFF ##0 !RUNNING_O)
        else $error("held remote did not continue dose cycle");
    chk_batch_last: assert property (
        state == ST_BATCH_WAIT && expire && remain == TIME_W'(1)
        && !key.stop && !key.start |=> state == ST_IDLE && remain == '0)
        else $error("batch did not stop at zero count");
    chk_direction_excl: assert property (
        !(CLOCKWISE_RUN_O && COUNTERCLOCKWISE_RUN_O)
        && (RUNNING_O == (CLOCKWISE_RUN_O || COUNTERCLOCKWISE_RUN_O)))
        else $error("direction outputs inconsistent");

endmodule

// >>> rtl/pump_seq_cfg.svh
`ifndef PUMP_SEQ_CFG_SVH
`define PUMP_SEQ_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define ADDR_W 8
`define REG_MODE 8'h00
`define REG_RUN_TIME 8'h04
`define REG_IDLE_TIME 8'h08
`define REG_BATCH_LOAD 8'h0c
`define REG_KEY_CMD 8'h10
`define REG_STATUS 8'h14

// ****************************************
// Field positions
// ****************************************
`define KEY_START_FWD_BIT 0
`define KEY_START_REV_BIT 1
`define KEY_STOP_BIT 2
`define STAT_RUNNING_BIT 0
`define STAT_REV_BIT 1
`define STAT_REMOTE_BIT 2
`define STAT_REMAIN_LSB 16

// ****************************************
// Reset values
// ****************************************
`define RST_MODE 2'h0
`define RST_RUN_TIME 16'h03e8
`define RST_IDLE_TIME 16'h03e8
`define RST_BATCH_LOAD 16'h000a

// ****************************************
// Timing
// ****************************************
`define MCLK_PERIOD_NS 40
`define TICK_PERIOD_NS 1000000
`define TICK_CYCLES (`TICK_PERIOD_NS / `MCLK_PERIOD_NS)
`define DEBOUNCE_MS 10

`endif

// >>> rtl/pump_seq_pkg.sv
package pump_seq_pkg;

    typedef enum logic [1:0] {
        MODE_MANUAL,
        MODE_TIMED,
        MODE_DOSE,
        MODE_BATCH
    } mode_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RUN,
        ST_DOSE_ON,
        ST_DOSE_OFF,
        ST_BATCH_ON,
        ST_BATCH_WAIT
    } seq_state_t;

    typedef struct packed {
        logic stop;
        logic start;
        logic rev;
    } key_cmd_t;

    typedef struct packed {
        logic req;
        logic rise;
        logic rev;
    } remote_t;

endpackage

// >>> rtl/remote_input_filter.sv
`timescale 1ns/1ns

module remote_input_filter #(
    parameter int DEB_TICKS = 10
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic raw_i,
    output logic clean_o
);

    localparam int CNT_W = $clog2(DEB_TICKS + 1);

    logic sync_a;
    logic sync_b;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic next_clean;

    // ****************************************
    // Two-flop synchroniser
    // ****************************************
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end else begin
            sync_a <= raw_i;
            sync_b <= sync_a;
        end
    end

    // ****************************************
    // Debounce: level must hold for DEB_TICKS
    // ****************************************
    always_comb begin
        next_cnt = cnt;
        next_clean = clean_o;
        if (sync_b == clean_o) begin
            next_cnt = '0;
        end else if (tick_i) begin
            if (cnt == CNT_W'(DEB_TICKS - 1)) begin
                next_clean = sync_b;
                next_cnt = '0;
            end else begin
                next_cnt = cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= '0;
            clean_o <= 1'b0;
        end else begin
            cnt <= next_cnt;
            clean_o <= next_clean;
        end
    end

endmodule

// >>> bench/remote_contact_model.sv
`timescale 1ns/1ns

// ****************************************
// Remote contact pair at the far side
// ****************************************
module remote_contact_model (
    input wire logic clk_i,
    input wire logic fwd_hold_i,
    input wire logic rev_hold_i,
    output logic fwd_o = 1'b0,
    output logic rev_o = 1'b0
);
    // Contacts follow the hold inputs one clock later, even mid-run
    always @(posedge clk_i) begin
        fwd_o <= fwd_hold_i;
        rev_o <= rev_hold_i;
    end
endmodule

// >>> bench/test_pump_run_mode_sequencer.sv
`timescale 1ns/1ns
`include "pump_seq_cfg.svh"

module test_pump_run_mode_sequencer;
    localparam int TK = 4;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wstb = 1'b0;
    logic rstb = 1'b0;
    logic fwd_hold = 1'b0;
    logic rev_hold = 1'b0;
    logic [31:0] rdata;
    logic [31:0] st;
    logic fwd;
    logic rev;
    logic running;
    logic stopped;
    logic fwd_on;
    logic rev_on;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;
    int n;

    // ****************************************
    // Clock, timeout, instances
    // ****************************************
    always #20 mclk = ~mclk;

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            $display("[ERR] %0t timeout", $time);
            give_verdict();
        end
    end

    remote_contact_model remote_contact_model_inst (
        .clk_i(mclk),
        .fwd_hold_i(fwd_hold),
        .rev_hold_i(rev_hold),
        .fwd_o(fwd),
        .rev_o(rev)
    );

    pump_run_mode_sequencer #(
        .TICK_CYCLES(TK),
        .DEB_TICKS(2),
        .TIME_W(16)
    ) pump_run_mode_sequencer_inst (
        .MCLK_I(mclk),
        .RST_I(rst),
        .ADDR_I(addr),
        .WDATA_I(wdata),
        .WSTB_I(wstb),
        .RSTB_I(rstb),
        .RDATA_O(rdata),
        .FWD_RUN_I(fwd),
        .REV_RUN_I(rev),
        .RUNNING_O(running),
        .STOPPED_O(stopped),
        .CLOCKWISE_RUN_O(fwd_on),
        .COUNTERCLOCKWISE_RUN_O(rev_on)
    );

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic give_verdict();
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wstb <= 1'b1;
        @(posedge mclk);
        wstb <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        rstb <= 1'b1;
        @(posedge mclk);
        rstb <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic wait_run(input logic val, input int max, output int k);
        k = 0;
        while (running !== val && k < max) begin
            @(posedge mclk);
            #1;
            k++;
        end
        chk_word({31'h0, running}, {31'h0, val});
        chk_word({31'h0, stopped}, {31'h0, ~val});
    endtask

    task automatic idle_cycles(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        chk_word({30'h0, running, stopped}, 32'h1);
        rd(`REG_MODE, st);
        chk_word(st, 32'h0);
        rd(`REG_RUN_TIME, st);
        chk_word(st, 32'h3e8);
        rd(`REG_IDLE_TIME, st);
        chk_word(st, 32'h3e8);
        rd(`REG_BATCH_LOAD, st);
        chk_word(st, 32'ha);
        rd(8'h40, st);
        chk_word(st, 32'h0);
    endtask

    task automatic t_manual_key();
        wr(`REG_KEY_CMD, 32'h2);
        chk_word({29'h0, running, fwd_on, rev_on}, 32'h5);
        idle_cycles(30);
        chk_word({31'h0, running}, 32'h1);
        wr(`REG_KEY_CMD, 32'h4);
        chk_word({30'h0, running, stopped}, 32'h1);
        wr(`REG_KEY_CMD, 32'h5);
        chk_word({31'h0, running}, 32'h0);
    endtask

    task automatic t_manual_remote();
        for (int d = 0; d < 2; d++) begin
            @(posedge mclk);
            fwd_hold <= (d == 0);
            rev_hold <= (d == 1);
            wait_run(1'b1, 40, n);
            chk_word({30'h0, fwd_on, rev_on}, (d == 0) ? 32'h2 : 32'h1);
            idle_cycles(20);
            chk_word({31'h0, running}, 32'h1);
            fwd_hold <= 1'b0;
            rev_hold <= 1'b0;
            wait_run(1'b0, 40, n);
        end
    endtask

    task automatic t_timed();
        wr(`REG_MODE, 32'h1);
        wr(`REG_RUN_TIME, 32'h3);
        wr(`REG_KEY_CMD, 32'h1);
        chk_word({31'h0, running}, 32'h1);
        wait_run(1'b0, 40, n);
        chk_word({31'h0, n >= 7 && n <= 14}, 32'h1);
        wr(`REG_KEY_CMD, 32'h1);
        idle_cycles(4);
        wr(`REG_KEY_CMD, 32'h1);
        wait_run(1'b0, 40, n);
        chk_word({31'h0, n >= 8}, 32'h1);
        @(posedge mclk);
        fwd_hold <= 1'b1;
        wait_run(1'b1, 40, n);
        wait_run(1'b0, 40, n);
        idle_cycles(40);
        chk_word({31'h0, running}, 32'h0);
        fwd_hold <= 1'b0;
        idle_cycles(20);
    endtask

    task automatic t_dose();
        wr(`REG_MODE, 32'h2);
        wr(`REG_RUN_TIME, 32'h2);
        wr(`REG_IDLE_TIME, 32'h2);
        wr(`REG_KEY_CMD, 32'h1);
        wait_run(1'b0, 20, n);
        wait_run(1'b1, 20, n);
        wait_run(1'b0, 20, n);
        wait_run(1'b1, 20, n);
        wr(`REG_KEY_CMD, 32'h4);
        chk_word({31'h0, running}, 32'h0);
        @(posedge mclk);
        fwd_hold <= 1'b1;
        wait_run(1'b1, 40, n);
        wait_run(1'b0, 20, n);
        wait_run(1'b1, 20, n);
        fwd_hold <= 1'b0;
        wait_run(1'b0, 60, n);
        idle_cycles(40);
        chk_word({31'h0, running}, 32'h0);
    endtask

    task automatic t_batch();
        wr(`REG_MODE, 32'h3);
        wr(`REG_RUN_TIME, 32'h3);
        wr(`REG_IDLE_TIME, 32'h2);
        wr(`REG_BATCH_LOAD, 32'h2);
        wr(`REG_KEY_CMD, 32'h1);
        rd(`REG_STATUS, st);
        chk_word({st[31:16], 15'h0, st[0]}, 32'h20001);
        wait_run(1'b0, 20, n);
        wait_run(1'b1, 20, n);
        wait_run(1'b0, 20, n);
        idle_cycles(40);
        chk_word({31'h0, running}, 32'h0);
        rd(`REG_STATUS, st);
        chk_word({16'h0, st[31:16]}, 32'h0);
        // Held request reloads the count and runs it down to zero
        @(posedge mclk);
        fwd_hold <= 1'b1;
        wait_run(1'b1, 40, n);
        idle_cycles(60);
        rd(`REG_STATUS, st);
        chk_word({st[31:16], 15'h0, st[0]}, 32'h0);
        fwd_hold <= 1'b0;
        idle_cycles(20);
        // Brief pulse doses one count, then stops
        fwd_hold <= 1'b1;
        idle_cycles(12);
        fwd_hold <= 1'b0;
        wait_run(1'b1, 20, n);
        wait_run(1'b0, 20, n);
        idle_cycles(30);
        rd(`REG_STATUS, st);
        chk_word({st[31:16], 15'h0, st[0]}, 32'h10000);
    endtask

    task automatic t_priority();
        wr(`REG_MODE, 32'h0);
        wr(`REG_KEY_CMD, 32'h2);
        @(posedge mclk);
        fwd_hold <= 1'b1;
        idle_cycles(25);
        fwd_hold <= 1'b0;
        idle_cycles(25);
        chk_word({29'h0, running, fwd_on, rev_on}, 32'h5);
        wr(`REG_KEY_CMD, 32'h4);
        chk_word({31'h0, running}, 32'h0);
    endtask

    task automatic t_mid_reset();
        wr(`REG_MODE, 32'h2);
        wr(`REG_KEY_CMD, 32'h1);
        chk_word({31'h0, running}, 32'h1);
        @(posedge mclk);
        rst <= 1'b1;
        idle_cycles(2);
        chk_word({30'h0, running, stopped}, 32'h1);
        @(posedge mclk);
        rst <= 1'b0;
        #1;
        chk_word({30'h0, running, stopped}, 32'h1);
        rd(`REG_MODE, st);
        chk_word(st, 32'h0);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        #1;
        t_reset();
        t_manual_key();
        t_manual_remote();
        t_timed();
        t_dose();
        t_batch();
        t_priority();
        t_mid_reset();
        give_verdict();
    end
endmodule
